// file: rtl/dhrc_channel.sv
// Purpose: Per-channel control for peripheral-triggered DMA transfers
// Assumes: APB slave with zero wait states; peripheral lines synchronous to pclk
// Notes:   xfer_beat stands in for one bus beat of the datapath
// How it works
// - Pause state performs no transfer and never clears the request.
// - Cancelling pause returns the channel to Transfer state.
// - Demand level held across pause resumes transfer and is cleared normally.
// - Block mode acts on rising edges only; a held level starts nothing.
// - Disable state neither starts transfers nor clears the request.
// - Demand level present on entering wait goes straight to Transfer.
// - Waiting channel disables on disable or pause command; stop status unchanged.
// - Request is masked while the peripheral stop request is high.
// - With enable clear mask set, completion keeps enable and returns to wait.
// - Stop request in Transfer aborts, clears pause and trigger (and enable unless em is set), status stop, error event.
// - Global enable, channel enable, no halt and no pause enter wait.
// - Block edge arriving mid-block is ignored but its request is cleared.
`timescale 1ns/100ps
module dhrc_channel
  import dhrc_pkg::*;
#(
  parameter int TC_W = 16,
  parameter int BC_W = 4
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        per_req,
  input  wire logic        per_stop,
  output logic             req_clear,
  output logic             xfer_beat,
  output logic             error_event,
  output logic             done_event
);

  // Counts must fit their register fields
  if (TC_W < 1 || TC_W > 16 || BC_W < 1 || BC_W > 8) begin : g_bad_width
    $error("dhrc_channel: count width out of range");
  end

  typedef struct packed {
    dhrc_state_t            st;
    logic                   gl_en;
    logic [DHRC_HALT_W-1:0] halt;
    logic                   ch_en;
    logic                   pause;
    logic                   swtrig;
    dhrc_mode_t             mode;
    logic                   em;
    logic                   ei;
    logic                   ci;
    logic [DHRC_SRC_W-1:0]  src;
    logic [TC_W-1:0]        tc_set;
    logic [BC_W-1:0]        bc_set;
    logic [TC_W-1:0]        tc_rem;
    logic [BC_W-1:0]        bc_rem;
    logic                   busy;
    logic [1:0]             cool;
    logic [2:0]             ss;
    logic [31:0]            prdata;
    logic                   clr;
    logic                   beat;
    logic                   err_ev;
    logic                   done_ev;
  } dhrc_chan_t;

  dhrc_chan_t  q_r;
  dhrc_chan_t  q_nxt;
  dhrc_req_if  rq ();
  logic        wr_acc;
  logic        mapped;
  logic        go;
  logic        run_ok;
  logic        complete;
  logic        stop_hit;
  logic [31:0] rd_v;

  // Stop request masks the request before sampling
  assign rq.masked_req = per_req & ~per_stop;

  dhrc_req_edge u_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .rq      (rq)
  );

  // APB decode; zero wait states keeps the master simple
  assign wr_acc  = psel & penable & pwrite;
  assign mapped  = (paddr == DHRC_OFS_GLOBAL) || (paddr == DHRC_OFS_CHAN) ||
                   (paddr == DHRC_OFS_COUNT) || (paddr == DHRC_OFS_STAT);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // Enable conditions for the wait state and for running
  assign go       = q_r.gl_en & q_r.ch_en & (q_r.halt == DHRC_HALT_NONE) & ~q_r.pause;
  assign run_ok   = go & ~per_stop;
  assign stop_hit = per_stop & (q_r.st == DHRC_XFER);

  // Read mux, unused bits read as zero
  always_comb begin
    rd_v = '0;
    unique case (paddr)
      DHRC_OFS_GLOBAL: begin
        rd_v[DHRC_GL_EN_BIT]                   = q_r.gl_en;
        rd_v[DHRC_GL_HALT_LSB +: DHRC_HALT_W]  = q_r.halt;
      end
      DHRC_OFS_CHAN: begin
        rd_v[DHRC_CH_EN_BIT]                   = q_r.ch_en;
        rd_v[DHRC_CH_PAUSE_BIT]                = q_r.pause;
        rd_v[DHRC_CH_SWTRG_BIT]                = q_r.swtrig;
        rd_v[DHRC_CH_MODE_LSB +: 2]            = q_r.mode;
        rd_v[DHRC_CH_EM_BIT]                   = q_r.em;
        rd_v[DHRC_CH_EI_BIT]                   = q_r.ei;
        rd_v[DHRC_CH_CI_BIT]                   = q_r.ci;
        rd_v[DHRC_CH_SRC_LSB +: DHRC_SRC_W]    = q_r.src;
      end
      DHRC_OFS_COUNT: begin
        rd_v[DHRC_CNT_TC_LSB +: TC_W]          = q_r.tc_set;
        rd_v[DHRC_CNT_BC_LSB +: BC_W]          = q_r.bc_set;
      end
      DHRC_OFS_STAT: begin
        rd_v[DHRC_ST_STATE_LSB +: 4]           = q_r.st;
        rd_v[DHRC_ST_SS_LSB +: 3]              = q_r.ss;
        rd_v[DHRC_ST_BUSY_BIT]                 = q_r.busy;
        rd_v[DHRC_ST_TCREM_LSB +: TC_W]        = q_r.tc_rem;
      end
      default: rd_v = '0;
    endcase
  end

  // Whole next state: bus writes first, so hardware updates below win
  always_comb begin
    q_nxt         = q_r;
    complete      = 1'b0;
    q_nxt.clr     = 1'b0;
    q_nxt.beat    = 1'b0;
    q_nxt.err_ev  = 1'b0;
    q_nxt.done_ev = 1'b0;
    if (q_r.cool != 2'h0) begin
      q_nxt.cool = q_r.cool - 2'h1;
    end
    if (psel & ~penable) begin
      q_nxt.prdata = rd_v;
    end
    if (wr_acc) begin
      unique case (paddr)
        DHRC_OFS_GLOBAL: begin
          q_nxt.gl_en = pwdata[DHRC_GL_EN_BIT];
          q_nxt.halt  = pwdata[DHRC_GL_HALT_LSB +: DHRC_HALT_W];
        end
        DHRC_OFS_CHAN: begin
          q_nxt.ch_en  = pwdata[DHRC_CH_EN_BIT];
          q_nxt.pause  = pwdata[DHRC_CH_PAUSE_BIT];
          q_nxt.swtrig = pwdata[DHRC_CH_SWTRG_BIT];
          q_nxt.mode   = dhrc_mode_t'(pwdata[DHRC_CH_MODE_LSB +: 2]);
          q_nxt.em     = pwdata[DHRC_CH_EM_BIT];
          q_nxt.ei     = pwdata[DHRC_CH_EI_BIT];
          q_nxt.ci     = pwdata[DHRC_CH_CI_BIT];
          q_nxt.src    = pwdata[DHRC_CH_SRC_LSB +: DHRC_SRC_W];
        end
        DHRC_OFS_COUNT: begin
          q_nxt.tc_set = pwdata[DHRC_CNT_TC_LSB +: TC_W];
          q_nxt.bc_set = pwdata[DHRC_CNT_BC_LSB +: BC_W];
          q_nxt.tc_rem = pwdata[DHRC_CNT_TC_LSB +: TC_W];
          q_nxt.bc_rem = pwdata[DHRC_CNT_BC_LSB +: BC_W];
        end
        DHRC_OFS_STAT: q_nxt.ss = DHRC_SS_NONE;  // Any write clears stop status
        default: ;
      endcase
    end

    unique case (q_r.st)
      DHRC_DISABLE: begin
        // Request is neither served nor cleared here
        if (go) begin
          q_nxt.st = DHRC_WAIT;
        end
      end
      DHRC_WAIT: begin
        if (!go) begin
          q_nxt.st = DHRC_DISABLE;  // Stop status left as is
        end else if (q_r.mode == DHRC_DEMAND && rq.level && q_r.cool == 2'h0) begin
          // Cool-down also guards a repeat rearm against the level just cleared
          q_nxt.st = DHRC_XFER;  // Served on the next cycle
        end else if (q_r.mode != DHRC_DEMAND && rq.rise) begin
          q_nxt.st     = DHRC_XFER;
          q_nxt.clr    = 1'b1;
          q_nxt.busy   = 1'b1;
          q_nxt.bc_rem = q_r.bc_set;
        end
      end
      DHRC_XFER: begin
        if (per_stop) begin
          // Suspend at once; reload only in repeat mode
          q_nxt.ss     = DHRC_SS_STOP;
          q_nxt.err_ev = q_r.ei;
          q_nxt.pause  = 1'b0;
          q_nxt.swtrig = 1'b0;
          q_nxt.busy   = 1'b0;
          q_nxt.ch_en  = q_r.em & q_r.ch_en;
          q_nxt.st     = (q_r.em & q_r.ch_en) ? DHRC_WAIT : DHRC_DISABLE;
          if (q_r.em) begin
            q_nxt.tc_rem = q_r.tc_set;
            q_nxt.bc_rem = q_r.bc_set;
          end
        end else if (!q_r.ch_en || !q_r.gl_en) begin
          // Forced termination keeps the enable bits as software left them
          q_nxt.ss     = DHRC_SS_STOP;
          q_nxt.err_ev = q_r.ei;
          q_nxt.busy   = 1'b0;
          q_nxt.st     = DHRC_DISABLE;
        end else if (q_r.pause || q_r.halt != DHRC_HALT_NONE) begin
          q_nxt.st = DHRC_PAUSE;
        end else if (q_r.busy) begin
          q_nxt.beat = 1'b1;
          if (rq.rise) begin
            q_nxt.clr = 1'b1;  // Late edge dropped but cleared
          end
          if (q_r.bc_rem != '0) begin
            q_nxt.bc_rem = q_r.bc_rem - 1'b1;
          end else if (q_r.tc_rem == '0) begin
            complete = 1'b1;
          end else begin
            q_nxt.tc_rem = q_r.tc_rem - 1'b1;
            q_nxt.bc_rem = q_r.bc_set;
            q_nxt.busy   = (q_r.mode == DHRC_BURST);  // Burst needs one request only
          end
        end else if (q_r.mode == DHRC_DEMAND) begin
          // Cool-down lets the cleared level fall before it is sampled again
          if (rq.level && q_r.cool == 2'h0) begin
            q_nxt.beat = 1'b1;
            q_nxt.clr  = 1'b1;
            q_nxt.cool = DHRC_COOL_CYC;
            if (q_r.tc_rem == '0) begin
              complete = 1'b1;
            end else begin
              q_nxt.tc_rem = q_r.tc_rem - 1'b1;
            end
          end
        end else if (rq.rise) begin
          q_nxt.clr    = 1'b1;
          q_nxt.busy   = 1'b1;
          q_nxt.bc_rem = q_r.bc_set;
        end
      end
      DHRC_PAUSE: begin
        // Nothing served or cleared while paused
        if (!q_r.ch_en || !q_r.gl_en) begin
          q_nxt.ss     = DHRC_SS_STOP;
          q_nxt.err_ev = q_r.ei;
          q_nxt.busy   = 1'b0;
          q_nxt.st     = DHRC_DISABLE;
        end else if (!q_r.pause && q_r.halt == DHRC_HALT_NONE) begin
          q_nxt.st = DHRC_XFER;
        end
      end
      default: q_nxt.st = DHRC_DISABLE;
    endcase

    // Normal end: repeat mode keeps the enable and rearms
    if (complete) begin
      q_nxt.ss      = DHRC_SS_DONE;
      q_nxt.done_ev = q_r.ci;
      q_nxt.pause   = 1'b0;
      q_nxt.swtrig  = 1'b0;
      q_nxt.busy    = 1'b0;
      q_nxt.tc_rem  = q_r.tc_set;
      q_nxt.bc_rem  = q_r.bc_set;
      q_nxt.ch_en   = q_r.em & q_r.ch_en;
      q_nxt.st      = q_r.em ? DHRC_WAIT : DHRC_DISABLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r    <= '0;
      q_r.st <= DHRC_DISABLE;
    end else begin
      q_r <= q_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign prdata      = q_r.prdata;
  assign req_clear   = q_r.clr;
  assign xfer_beat   = q_r.beat;
  assign error_event = q_r.err_ev;
  assign done_event  = q_r.done_ev;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_demand_wait;
    q_r.st == DHRC_WAIT && go && q_r.mode == DHRC_DEMAND && rq.level && !per_stop && q_r.cool == 2'h0;
  endsequence

  sequence s_serve_next;
    q_r.st == DHRC_XFER ##1 (req_clear || per_stop || $past(per_stop) || !run_ok);
  endsequence

  chk_pause_no_clear: assert property (q_r.st == DHRC_PAUSE |=> !req_clear && !xfer_beat)
    else $error("request served or cleared in pause");
  chk_unpause_resume: assert property (q_r.st == DHRC_PAUSE && go |=> q_r.st == DHRC_XFER)
    else $error("pause cancel did not resume");
  chk_demand_serve: assert property (q_r.st == DHRC_XFER && run_ok && !q_r.busy && q_r.mode == DHRC_DEMAND
    && rq.level && q_r.cool == 2'h0 |=> req_clear && xfer_beat)
    else $error("demand level not served");
  chk_block_edge_only: assert property (req_clear && q_r.mode != DHRC_DEMAND |-> $past(rq.rise))
    else $error("block request cleared without edge");
  chk_disable_quiet: assert property (q_r.st == DHRC_DISABLE |=> !req_clear && !xfer_beat)
    else $error("disabled channel touched request");
  chk_demand_wait: assert property (s_demand_wait |=> s_serve_next)
    else $error("demand level in wait not served at once");
  chk_wait_cancel: assert property (q_r.st == DHRC_WAIT && !go |=> q_r.st == DHRC_DISABLE && $stable(q_r.ss))
    else $error("wait cancel wrong");
  chk_stop_mask: assert property (per_stop |=> !rq.level)
    else $error("request not masked by stop");
  chk_stop_abort: assert property (stop_hit |=> q_r.ss == DHRC_SS_STOP && !q_r.busy && !q_r.pause
    && error_event == $past(q_r.ei) && q_r.st != DHRC_XFER)
    else $error("stop request abort wrong");
  chk_enter_wait: assert property (q_r.st == DHRC_DISABLE && go |=> q_r.st == DHRC_WAIT)
    else $error("enable did not reach wait");
  chk_late_edge: assert property (q_r.st == DHRC_XFER && run_ok && q_r.busy && rq.rise |=> req_clear)
    else $error("late block edge not cleared");
  chk_repeat_keep: assert property (complete && q_r.em && q_r.ch_en |=> q_r.st == DHRC_WAIT && q_r.ch_en
    && q_r.ss == DHRC_SS_DONE)
    else $error("repeat mode lost enable");

endmodule

// file: rtl/dhrc_pkg.sv
// Purpose: Shared constants for the hardware-request channel controller
// Assumes: APB register map with one aligned 32-bit word per register
// Notes:   Mode and state codes are used by the top and the bench
package dhrc_pkg;

  // Register byte offsets
  localparam logic [7:0] DHRC_OFS_GLOBAL = 8'h00;
  localparam logic [7:0] DHRC_OFS_CHAN   = 8'h04;
  localparam logic [7:0] DHRC_OFS_COUNT  = 8'h08;
  localparam logic [7:0] DHRC_OFS_STAT   = 8'h0C;

  // Global register fields
  localparam int DHRC_GL_EN_BIT    = 0;
  localparam int DHRC_GL_HALT_LSB  = 4;
  localparam int DHRC_HALT_W       = 4;

  // Channel register fields
  localparam int DHRC_CH_EN_BIT    = 0;
  localparam int DHRC_CH_PAUSE_BIT = 1;
  localparam int DHRC_CH_SWTRG_BIT = 2;
  localparam int DHRC_CH_MODE_LSB  = 3;
  localparam int DHRC_CH_EM_BIT    = 5;
  localparam int DHRC_CH_EI_BIT    = 6;
  localparam int DHRC_CH_CI_BIT    = 7;
  localparam int DHRC_CH_SRC_LSB   = 8;
  localparam int DHRC_SRC_W        = 4;

  // Count and status register fields
  localparam int DHRC_CNT_TC_LSB   = 0;
  localparam int DHRC_CNT_BC_LSB   = 16;
  localparam int DHRC_ST_STATE_LSB = 0;
  localparam int DHRC_ST_SS_LSB    = 4;
  localparam int DHRC_ST_BUSY_BIT  = 7;
  localparam int DHRC_ST_TCREM_LSB = 16;

  // Constant values
  localparam logic [3:0] DHRC_HALT_NONE = 4'h0;
  localparam logic [2:0] DHRC_SS_NONE   = 3'h0;
  localparam logic [2:0] DHRC_SS_STOP   = 3'h2;
  localparam logic [2:0] DHRC_SS_DONE   = 3'h5;
  localparam logic [1:0] DHRC_COOL_CYC  = 2'h2;

  typedef enum logic [1:0] {
    DHRC_BLOCK  = 2'h0,
    DHRC_BURST  = 2'h1,
    DHRC_DEMAND = 2'h2
  } dhrc_mode_t;

  typedef enum logic [3:0] {
    DHRC_DISABLE = 4'h1,
    DHRC_WAIT    = 4'h2,
    DHRC_XFER    = 4'h4,
    DHRC_PAUSE   = 4'h8
  } dhrc_state_t;

endpackage

// file: rtl/dhrc_req_if.sv
// Purpose: Carrier between the channel top and its request sampler
// Assumes: One clock domain
// Notes:   Sampler owns level and rise; top owns the masked request
`timescale 1ns/100ps
interface dhrc_req_if;
  logic masked_req;
  logic level;
  logic rise;
  modport sampler (input masked_req, output level, output rise);
  modport owner   (output masked_req, input level, input rise);
endinterface

// file: rtl/dhrc_req_edge.sv
// Purpose: Registers the masked peripheral request and finds its rising edge
// Assumes: Request is synchronous to pclk
// Notes:   Previous sample keeps tracking in every state, so a held level never edges
`timescale 1ns/100ps
module dhrc_req_edge
  import dhrc_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  dhrc_req_if.sampler     rq
);

  typedef struct packed {
    logic cur;
    logic prev;
  } dhrc_smp_t;

  dhrc_smp_t q_r;
  dhrc_smp_t q_nxt;

  // Sample now, remember last sample for the edge compare
  always_comb begin
    q_nxt      = q_r;
    q_nxt.cur  = rq.masked_req;
    q_nxt.prev = q_r.cur;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  // Edge only where the level was low one sample before
  assign rq.level = q_r.cur;
  assign rq.rise  = q_r.cur & ~q_r.prev;

endmodule

// file: tb/dhrc_periph_model.sv
// Purpose: Peripheral model raising transfer and stop requests
// Assumes: Bench commands are one-cycle pulses or levels on pclk
// Notes:   Request is cause AND enable, so an enable toggle makes a new edge
`timescale 1ns/100ps
module dhrc_periph_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic set_cause,
  input  wire logic drop,
  input  wire logic irq_en,
  input  wire logic stop_lvl,
  input  wire logic req_clear,
  output logic      per_req,
  output logic      per_stop
);
  logic cause_r;
  // Cause flag falls one cycle after the channel clears it, as a real flag would
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_r <= 1'b0;
    end else if (set_cause) begin
      cause_r <= 1'b1;
    end else if (req_clear || drop) begin
      cause_r <= 1'b0;
    end
  end
  // Stop is a plain level; it never drops the request by itself
  assign per_req  = cause_r & irq_en;
  assign per_stop = stop_lvl;
endmodule

// file: tb/tb_top.sv
// Purpose: Self-checking bench for the hardware-request channel controller
// Assumes: Zero-wait APB slave; the bench commands the peripheral model
// Notes:   Event counts are deltas from a mark, so tests stay independent
`timescale 1ns/100ps
`define CHK(nm, x, g) begin checked++; if ((g) !== (x)) begin err_count++; $display("[ERR] %s exp %0h got %0h", nm, x, g); end end
module tb_top
  import dhrc_pkg::*;
;
  typedef struct packed {
    logic [31:0] glob;
    logic [31:0] chan;
    logic [3:0]  st;
  } dhrc_row_t;
  logic        pclk     = 1'b0;
  logic        presetn  = 1'b0;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h0;
  logic [1:0]  pcmd     = 2'h0;
  logic        irq_en   = 1'b1;
  logic        stop_lvl = 1'b0;
  logic [31:0] prdata, q;
  logic        pready, pslverr, per_req, per_stop, e;
  logic        req_clear, xfer_beat, error_event, done_event;
  wire  [3:0]  ev_v = {done_event, error_event, xfer_beat, req_clear};
  int          err_count = 0;
  int          checked = 0;
  int          ev_n[4] = '{0, 0, 0, 0};
  int          ev_b[4] = '{0, 0, 0, 0};
  // Software trigger bit 2 is always written as 0 in every row and test
  dhrc_row_t   rows[7] = '{'{32'h1, 32'h1, DHRC_WAIT}, '{32'h1, 32'h3, DHRC_DISABLE},
                           '{32'h1, 32'h11, DHRC_WAIT}, '{32'h1, 32'h0, DHRC_DISABLE},
                           '{32'h31, 32'h1, DHRC_DISABLE}, '{32'h1, 32'h1, DHRC_WAIT},
                           '{32'h0, 32'h1, DHRC_DISABLE}};

  dhrc_channel #(.TC_W(16), .BC_W(4)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .per_req(per_req), .per_stop(per_stop), .req_clear(req_clear), .xfer_beat(xfer_beat),
    .error_event(error_event), .done_event(done_event));
  dhrc_periph_model periph (
    .pclk(pclk), .presetn(presetn), .set_cause(pcmd[0]), .drop(pcmd[1]), .irq_en(irq_en),
    .stop_lvl(stop_lvl), .req_clear(req_clear), .per_req(per_req), .per_stop(per_stop));

  // Clock and watchdog
  always #5 pclk = ~pclk;
  initial begin
    repeat (50000) @(posedge pclk);
    err_count++;
    give_verdict();
  end
  // Pulse counters sampled on every rising edge
  always @(posedge pclk) begin
    foreach (ev_n[i]) ev_n[i] += int'(ev_v[i] === 1'b1);
  end

  task automatic give_verdict();
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // One APB transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rq, output logic re);
    int n;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rq = prdata;
    re = pslverr;
    if (pready !== 1'b1) begin
      err_count++;
      give_verdict();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rq;
    logic        re;
    apb(1'b1, a, d, rq, re);
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    logic [31:0] rq;
    logic        re;
    apb(1'b0, a, 32'h0, rq, re);
    `CHK(nm, x, rq & m)
  endtask
  task automatic st_chk(input logic [3:0] st, input logic [2:0] ss);
    rd_chk("status", DHRC_OFS_STAT, 32'h0000007F, {25'h0, ss, st});
  endtask
  // Polls the state field; a channel that never gets there ends the run
  task automatic wait_st(input logic [3:0] st);
    logic [31:0] rq;
    logic        re;
    int          n;
    n = 0;
    do begin
      apb(1'b0, DHRC_OFS_STAT, 32'h0, rq, re);
      n++;
    end while (rq[3:0] !== st && n < 200);
    if (rq[3:0] !== st) begin
      err_count++;
      give_verdict();
    end
  endtask
  task automatic pulse(input logic [1:0] c);
    pcmd <= c;
    @(posedge pclk);
    pcmd <= 2'h0;
    @(posedge pclk);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Channel is disabled first so counts are never rewritten while waiting
  task automatic prep(input logic [31:0] cnt, input logic [31:0] ch);
    wr(DHRC_OFS_CHAN, 32'h0);
    wr(DHRC_OFS_STAT, 32'h0);
    wr(DHRC_OFS_COUNT, cnt);
    wr(DHRC_OFS_GLOBAL, 32'h1);
    wr(DHRC_OFS_CHAN, ch);
    ev_b = ev_n;
  endtask
  task automatic ev_chk(input int c, input int b, input int r, input int d);
    int x[4];
    x = '{c, b, r, d};
    foreach (x[i]) `CHK($sformatf("event %0d count", i), x[i], ev_n[i] - ev_b[i])
  endtask

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values and an unmapped offset
    rd_chk("status rst", DHRC_OFS_STAT, 32'hFFFFFFFF, 32'h00000001);
    rd_chk("chan rst", DHRC_OFS_CHAN, 32'hFFFFFFFF, 32'h00000000);
    apb(1'b0, 8'h10, 32'h0, q, e);
    `CHK("pslverr", 1'b1, e)
    `CHK("unmapped data", 32'h0, q)
    $display("test reset done");
    // Enable, halt and pause combinations with no request pending
    foreach (rows[i]) begin
      wr(DHRC_OFS_GLOBAL, rows[i].glob);
      wr(DHRC_OFS_CHAN, rows[i].chan);
      st_chk(rows[i].st, DHRC_SS_NONE);
    end
    $display("test table done");
    // Block edge in wait, completion with success event
    prep(32'h00010000, 32'h81);
    pulse(2'h1);
    wait_st(DHRC_DISABLE);
    ev_chk(1, 2, 0, 1);
    st_chk(DHRC_DISABLE, DHRC_SS_DONE);
    $display("test block done");
    // Block request held through disable, then a fresh edge after enable toggle
    prep(32'h00010000, 32'h0);
    pulse(2'h1);
    idle(10);
    ev_chk(0, 0, 0, 0);
    wr(DHRC_OFS_CHAN, 32'h1);
    idle(10);
    st_chk(DHRC_WAIT, DHRC_SS_NONE);
    ev_chk(0, 0, 0, 0);
    irq_en <= 1'b0;
    @(posedge pclk);
    irq_en <= 1'b1;
    wait_st(DHRC_DISABLE);
    ev_chk(1, 2, 0, 0);
    $display("test held block done");
    // Demand level held in disable starts at once on enable
    prep(32'h0, 32'h10);
    pulse(2'h1);
    idle(5);
    wr(DHRC_OFS_CHAN, 32'h11);
    wait_st(DHRC_DISABLE);
    ev_chk(1, 1, 0, 0);
    st_chk(DHRC_DISABLE, DHRC_SS_DONE);
    $display("test held demand done");
    // Demand pause: request ignored, then served after pause is cancelled
    prep(32'h1, 32'h11);
    pulse(2'h1);
    idle(8);
    st_chk(DHRC_XFER, DHRC_SS_NONE);
    wr(DHRC_OFS_CHAN, 32'h13);
    pulse(2'h1);
    idle(10);
    st_chk(DHRC_PAUSE, DHRC_SS_NONE);
    ev_chk(1, 1, 0, 0);
    wr(DHRC_OFS_CHAN, 32'h11);
    wait_st(DHRC_DISABLE);
    ev_chk(2, 2, 0, 0);
    st_chk(DHRC_DISABLE, DHRC_SS_DONE);
    $display("test pause done");
    // Block pause: held level starts nothing after unpause, a fresh edge does
    prep(32'h1, 32'h1);
    pulse(2'h1);
    idle(5);
    wr(DHRC_OFS_CHAN, 32'h3);
    pulse(2'h1);
    idle(5);
    wr(DHRC_OFS_CHAN, 32'h1);
    idle(5);
    ev_chk(1, 1, 0, 0);
    pulse(2'h2);
    pulse(2'h1);
    wait_st(DHRC_DISABLE);
    ev_chk(2, 2, 0, 0);
    $display("test block pause done");
    // Stop request mid-transfer, then masking while stop stays high
    prep(32'h3, 32'h51);
    pulse(2'h1);
    idle(8);
    stop_lvl <= 1'b1;
    pulse(2'h1);
    idle(10);
    ev_chk(1, 1, 1, 0);
    st_chk(DHRC_DISABLE, DHRC_SS_STOP);
    rd_chk("chan ctl", DHRC_OFS_CHAN, 32'h00000007, 32'h0);
    prep(32'h0, 32'h11);
    idle(10);
    ev_chk(0, 0, 0, 0);
    st_chk(DHRC_WAIT, DHRC_SS_NONE);
    wr(DHRC_OFS_CHAN, 32'h0);
    pulse(2'h2);
    stop_lvl <= 1'b0;
    $display("test stop done");
    // Repeat mode returns to wait with enable kept
    prep(32'h0, 32'h71);
    pulse(2'h1);
    idle(10);
    ev_chk(1, 1, 0, 0);
    st_chk(DHRC_WAIT, DHRC_SS_DONE);
    rd_chk("chan en", DHRC_OFS_CHAN, 32'h1, 32'h1);
    $display("test repeat done");
    // Edge arriving while a block is busy is cleared but starts nothing
    prep(32'h00070001, 32'h1);
    pulse(2'h1);
    idle(3);
    pulse(2'h1);
    idle(20);
    ev_chk(2, 8, 0, 0);
    st_chk(DHRC_XFER, DHRC_SS_NONE);
    pulse(2'h1);
    wait_st(DHRC_DISABLE);
    ev_chk(3, 16, 0, 0);
    $display("test busy edge done");
    give_verdict();
  end
endmodule
